/* ssb_cfg.svh */
// constants of the sensor serial bus front end
`ifndef SSB_CFG_SVH
`define SSB_CFG_SVH
`define SSB_ADDR 7'h4a
`define SSB_DIR_RD 1'b1
`define SSB_CLK_HZ 20000000
`define SSB_CLK_NS 50
`define SSB_BOOT_MS 15
`define SSB_BOOT_CYC (`SSB_BOOT_MS * (`SSB_CLK_HZ / 1000))
`define SSB_SCL_HALF_NS 5000
`define SSB_SCL_HALF_CYC (`SSB_SCL_HALF_NS / `SSB_CLK_NS)
`define SSB_SDA_DLY 16'h0003
`define SSB_LAST_BIT 4'h8
`endif

/* ssb_pkg.sv */
// types shared by both ends of the sensor serial bus
package ssb_pkg;
  typedef enum logic [3:0] {
    SSB_D_BOOT, SSB_D_IDLE, SSB_D_ADDR, SSB_D_ACK_OUT, SSB_D_RX, SSB_D_TX, SSB_D_ACK_IN,
    SSB_D_IGNORE
  } ssb_dev_st_t;
  typedef enum logic [3:0] {
    SSB_H_BOOT, SSB_H_IDLE, SSB_H_START, SSB_H_LOW, SSB_H_WAIT, SSB_H_HIGH, SSB_H_STOP,
    SSB_H_SWAIT, SSB_H_SHIGH, SSB_H_FREE
  } ssb_host_st_t;
endpackage : ssb_pkg

/* ssb_bus_if.sv */
// two-wire bus between master and sensor, with pull-ups resolved here
`timescale 1ns/10ps
`default_nettype none
interface ssb_bus_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  // open drain: a driven low wins, otherwise the pull-up gives high
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
               output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : ssb_bus_if
`default_nettype wire

/* ssb_host.sv */
// bus master end: one header plus one data byte per command, or the header alone when the sensor does not acknowledge it
`timescale 1ns/10ps
`default_nettype none
`include "ssb_cfg.svh"
module ssb_host #(
  parameter int BOOT_CYC = `SSB_BOOT_CYC,
  parameter int SCL_HALF = `SSB_SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  ssb_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_stb,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import ssb_pkg::*;

  localparam int BOOT_W = $clog2(BOOT_CYC + 1);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    ssb_host_st_t st;
    logic [BOOT_W-1:0] boot;
    logic [15:0] cnt;
    logic [3:0] bitc;
    logic byte_i;
    logic rd;
    logic [7:0] sh;
    logic [7:0] dat;
    logic scl_oe;
    logic sda_oe;
    logic rdy;
    logic stb;
    logic nack;
  } ssb_host_t;

  ssb_host_t q;
  ssb_host_t n;
  logic tx_frame;
  logic half_end;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    n.scl_m = bus.scl;
    n.scl_s = q.scl_m;
    n.sda_m = bus.sda;
    n.sda_s = q.sda_m;
    n.stb = 1'b0;
    tx_frame = ~q.byte_i | ~q.rd;
    half_end = q.cnt == 16'(SCL_HALF - 1);
    unique case (q.st)
      SSB_H_BOOT: begin
        n.boot = q.boot + BOOT_W'(1);
        // no command until the sensor has had its start-up time
        if (q.boot == BOOT_W'(BOOT_CYC - 1)) begin // R6
          n.st = SSB_H_IDLE;
          n.rdy = 1'b1;
        end
      end
      SSB_H_IDLE: begin
        if (cmd_valid && q.rdy) begin
          n.rdy = 1'b0;
          n.rd = cmd_rd;
          n.sh = {`SSB_ADDR, cmd_rd}; // R13
          n.dat = cmd_data;
          n.byte_i = 1'b0;
          n.bitc = 4'h0;
          n.cnt = 16'h0000;
          n.nack = 1'b0;
          n.sda_oe = 1'b1; // R8
          n.st = SSB_H_START;
        end
      end
      SSB_H_START: begin
        n.cnt = q.cnt + 16'h0001;
        if (half_end) begin
          n.scl_oe = 1'b1;
          n.cnt = 16'h0000;
          n.st = SSB_H_LOW;
        end
      end
      SSB_H_LOW: begin
        n.cnt = q.cnt + 16'h0001;
        // data moves only well after the falling edge, never while high
        if (q.cnt == `SSB_SDA_DLY) begin // R2
          n.sda_oe = tx_frame && (q.bitc != `SSB_LAST_BIT) && !q.sh[7]; // R1 R5
        end
        if (half_end) begin
          n.scl_oe = 1'b0; // R5
          n.cnt = 16'h0000;
          n.st = SSB_H_WAIT;
        end
      end
      SSB_H_WAIT: begin
        // a sensor holding the clock low stretches this phase
        if (q.scl_s) begin
          n.cnt = 16'h0000;
          n.st = SSB_H_HIGH;
        end
      end
      SSB_H_HIGH: begin
        n.cnt = q.cnt + 16'h0001;
        if (half_end) begin
          n.scl_oe = 1'b1;
          n.cnt = 16'h0000;
          n.st = SSB_H_LOW;
          if (q.bitc == `SSB_LAST_BIT) begin
            n.bitc = 4'h0;
            if (tx_frame && q.sda_s) begin
              n.nack = 1'b1;
              n.st = SSB_H_STOP;
            end else if (q.byte_i) begin
              n.st = SSB_H_STOP;
            end else begin
              n.byte_i = 1'b1;
              n.sh = q.dat;
            end
          end else begin
            n.bitc = q.bitc + 4'h1;
            n.sh = {q.sh[6:0], q.sda_s};
          end
        end
      end
      SSB_H_STOP: begin
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt == `SSB_SDA_DLY) begin
          n.sda_oe = 1'b1;
        end
        if (half_end) begin
          n.scl_oe = 1'b0;
          n.cnt = 16'h0000;
          n.st = SSB_H_SWAIT;
        end
      end
      SSB_H_SWAIT: begin
        if (q.scl_s) begin
          n.cnt = 16'h0000;
          n.st = SSB_H_SHIGH;
        end
      end
      SSB_H_SHIGH: begin
        n.cnt = q.cnt + 16'h0001;
        if (half_end) begin
          n.sda_oe = 1'b0; // R8
          n.cnt = 16'h0000;
          n.st = SSB_H_FREE;
        end
      end
      SSB_H_FREE: begin
        // bus stays free a half period before the next start
        n.cnt = q.cnt + 16'h0001;
        if (half_end) begin // R11
          n.stb = 1'b1;
          n.rdy = 1'b1;
          n.st = SSB_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1, st: SSB_H_BOOT, default: '0};
    end else begin
      q <= n;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_oe = q.sda_oe;
  assign cmd_ready = q.rdy;
  assign rsp_stb = q.stb;
  assign rsp_data = q.sh;
  assign rsp_nack = q.nack;
endmodule : ssb_host
`default_nettype wire

/* ssb_dev.sv */
// sensor end of the two-wire bus: bit timing, framing, address, hold
//
// Notes on behaviour
// R1: master sets data valid before clock rise
// R2: master changes data only after clock falls
// R3: sensor changes data after fall, holds till next
// R4: fully static, no minimum clock rate
// R5: master only pulls lines low
// R6: ready within 15 ms while clock high
// R7: idle means sleep without any command
// R8: transactions framed by start and stop
// R9: data falling while clock high is start
// R10: data rising while clock high is stop
// R11: after stop, wait for a fresh start
// R12: one fixed address, no selection input
// R13: header is address plus direction bit
// R14: acknowledge each received byte after eighth fall
// R15: hold clock low while measuring in hold mode
// R16: foreign address ignored until next start
`timescale 1ns/10ps
`default_nettype none
`include "ssb_cfg.svh"
module ssb_dev #(
  parameter int BOOT_CYC = `SSB_BOOT_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  ssb_bus_if.dev bus,
  input wire logic [7:0] tx_data,
  input wire logic rd_ack_en,
  input wire logic hold_req,
  input wire logic meas_busy,
  output logic [7:0] rx_data,
  output logic rx_stb,
  output logic hdr_stb,
  output logic hdr_rd,
  output logic tx_stb,
  output logic ready,
  output logic busy,
  output logic sleep
);
  import ssb_pkg::*;

  localparam int BOOT_W = $clog2(BOOT_CYC + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    ssb_dev_st_t st;
    logic [BOOT_W-1:0] boot;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rw;
    logic sda_oe;
    logic scl_oe;
    logic [7:0] rx_data;
    logic rx_stb;
    logic hdr_stb;
    logic tx_stb;
    logic ready;
    logic busy;
    logic sleep;
  } ssb_dev_t;

  ssb_dev_t q;
  ssb_dev_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic active;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    // the first stage of each synchroniser feeds only the second
    n.scl_m = bus.scl;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = bus.sda;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    n.rx_stb = 1'b0;
    n.hdr_stb = 1'b0;
    n.tx_stb = 1'b0;

    // edges are found from sampled levels, so nothing needs a running
    // clock; state simply waits while the bus clock stands still
    scl_rise = q.scl_s & ~q.scl_p; // R4
    scl_fall = ~q.scl_s & q.scl_p;
    start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s; // R9
    stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s; // R10

    unique case (q.st)
      SSB_D_BOOT: begin
        // start-up time only advances while the clock line is high
        if (q.scl_s) begin
          n.boot = q.boot + BOOT_W'(1);
        end
        if (q.boot == BOOT_W'(BOOT_CYC - 1)) begin // R6
          n.st = SSB_D_IDLE;
        end
      end
      SSB_D_IDLE: begin
        // nothing to do until a start appears
      end
      SSB_D_ADDR: begin
        if (scl_rise) begin
          n.sh = {q.sh[6:0], q.sda_s};
          n.bitc = q.bitc + 4'h1;
        end
        if (scl_fall && q.bitc == `SSB_LAST_BIT) begin
          // a polled read is only acknowledged once data is ready
          if (q.sh[7:1] == `SSB_ADDR && (q.sh[0] != `SSB_DIR_RD || rd_ack_en)) begin // R12 R13
            n.sda_oe = 1'b1; // R14
            n.rw = q.sh[0];
            n.hdr_stb = 1'b1;
            n.busy = 1'b1;
            n.st = SSB_D_ACK_OUT;
          end else begin
            n.st = SSB_D_IGNORE; // R16
          end
        end
      end
      SSB_D_ACK_OUT: begin
        if (scl_fall) begin
          n.bitc = 4'h0;
          if (q.rw == `SSB_DIR_RD) begin
            // first data bit goes out on the same fall that ends the ack
            n.sh = tx_data;
            n.sda_oe = ~tx_data[7]; // R3
            n.tx_stb = 1'b1;
            n.st = SSB_D_TX;
          end else begin
            n.sda_oe = 1'b0;
            n.st = SSB_D_RX;
          end
        end
      end
      SSB_D_RX: begin
        if (scl_rise) begin
          n.sh = {q.sh[6:0], q.sda_s};
          n.bitc = q.bitc + 4'h1;
        end
        if (scl_fall && q.bitc == `SSB_LAST_BIT) begin
          n.rx_data = q.sh;
          n.rx_stb = 1'b1;
          n.sda_oe = 1'b1; // R14
          n.st = SSB_D_ACK_OUT;
        end
      end
      SSB_D_TX: begin
        if (scl_rise) begin
          n.bitc = q.bitc + 4'h1;
        end
        if (scl_fall) begin
          if (q.bitc == `SSB_LAST_BIT) begin
            n.sda_oe = 1'b0;
            n.st = SSB_D_ACK_IN;
          end else begin
            // bit changes only here, so it holds across the high phase
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = ~q.sh[6]; // R3
          end
        end
      end
      SSB_D_ACK_IN: begin
        if (scl_rise && q.sda_s) begin
          // master declined more data: stay off the bus
          n.st = SSB_D_IGNORE;
        end else if (scl_fall) begin
          n.bitc = 4'h0;
          n.sh = tx_data;
          n.sda_oe = ~tx_data[7]; // R3
          n.tx_stb = 1'b1;
          n.st = SSB_D_TX;
        end
      end
      SSB_D_IGNORE: begin
        n.sda_oe = 1'b0; // R16
      end
    endcase

    // framing conditions take precedence over any bit activity
    if (q.st != SSB_D_BOOT) begin
      if (start_c) begin
        n.st = SSB_D_ADDR; // R8 R9
        n.bitc = 4'h0;
        n.sda_oe = 1'b0;
      end else if (stop_c) begin
        n.st = SSB_D_IDLE; // R10 R11
        n.sda_oe = 1'b0;
      end
    end

    // ---------------------------------------------------------------
    // clock hold
    // ---------------------------------------------------------------
    active = n.st == SSB_D_ACK_OUT || n.st == SSB_D_RX || n.st == SSB_D_TX ||
             n.st == SSB_D_ACK_IN;
    // grab the clock only on a fresh fall: the synced level lags the wire,
    // so a stale low could cut a new high phase short; release as soon as
    // processing ends
    if (!hold_req || !active) begin
      n.scl_oe = 1'b0; // R15
    end else if (scl_fall) begin
      n.scl_oe = 1'b1; // R15
    end

    n.busy = active;
    n.ready = n.st != SSB_D_BOOT;
    // sleeping only when idle or in the ignore state (foreign address, unacked read, master nack), and not measuring
    n.sleep = (n.st == SSB_D_IDLE || n.st == SSB_D_IGNORE) && !meas_busy; // R7
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
             sda_p: 1'b1, st: SSB_D_BOOT, default: '0};
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe = q.scl_oe;
  assign bus.dev_sda_oe = q.sda_oe;
  assign rx_data = q.rx_data;
  assign rx_stb = q.rx_stb;
  assign hdr_stb = q.hdr_stb;
  assign hdr_rd = q.rw;
  assign tx_stb = q.tx_stb;
  assign ready = q.ready;
  assign busy = q.busy;
  assign sleep = q.sleep;
endmodule : ssb_dev
`default_nettype wire

/* ssb_asserts.sv */
// concurrent checks on the two-wire bus between host and sensor ends
`timescale 1ns/10ps
`default_nettype none
`include "ssb_cfg.svh"
module ssb_asserts #(
  parameter int BOOT_CYC = `SSB_BOOT_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // saturating count of cycles since reset release
  logic [31:0] boot_q;
  logic [31:0] boot_d;
  always_comb begin
    boot_d = (boot_q < 32'(BOOT_CYC)) ? boot_q + 32'h1 : boot_q;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_q <= '0;
    end else begin
      boot_q <= boot_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // wire rules
  // ----------------------------------------
  host_drive_low_a: assert property (!host_scl_o && !host_sda_o)
    else $error("host drives a line high");
  boot_quiet_a: assert property (boot_q < 32'(BOOT_CYC) |-> !host_sda_oe && !host_scl_oe)
    else $error("host touched the bus during start-up");
  host_setup_a: assert property ($fell(host_scl_oe) |=> $stable(host_sda_oe)[*4])
    else $error("host data moved around clock rise");
  host_change_a: assert property ($rose(host_scl_oe) |=> $stable(host_sda_oe)[*2])
    else $error("host data moved at clock fall");
  dev_data_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("sensor data moved while clock high");
  static_hold_a: assert property ((!scl)[*8] |-> $stable(dev_sda_oe))
    else $error("sensor data moved in a long low phase");
  start_frames_a: assert property ($rose(host_sda_oe) && scl |-> ##[1:40] host_scl_oe)
    else $error("start not followed by clocking");
  start_listen_a: assert property ($fell(sda) && scl && $past(scl) |=> (!dev_sda_oe)[*8])
    else $error("sensor drove data right after start");
  stop_free_a: assert property ($rose(sda) && scl && $past(scl)
    |=> (!dev_sda_oe && !dev_scl_oe)[*8])
    else $error("sensor active after stop");
  clock_hold_a: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("sensor grabbed clock while high");
endmodule : ssb_asserts
`default_nettype wire

/* sensor_serial_bus_front_end_bench.sv */
// self-checking bench: host end and sensor end joined over one bus
`timescale 1ns/10ps
`default_nettype none
module sensor_serial_bus_front_end_bench;
  localparam int BOOT = 20;
  localparam int HALF = 10;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic rsp_stb;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic [7:0] tx_data = 8'h00;
  logic rd_ack_en = 1'b1;
  logic hold_req = 1'b0;
  logic meas_busy = 1'b0;
  logic [7:0] rx_data;
  logic rx_stb;
  logic hdr_stb;
  logic hdr_rd;
  logic tx_stb;
  logic ready;
  logic busy;
  logic sleep;
  logic [7:0] rx_last = 8'h00;
  logic held_seen = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;
  int hdr_n = 0;
  int tx_n = 0;
  always #25 core_clk = ~core_clk;
  ssb_bus_if bus();
  ssb_host #(.BOOT_CYC(BOOT), .SCL_HALF(HALF)) ssb_host_i (.core_clk(core_clk),
    .arst_n(arst_n), .bus(bus), .cmd_valid(cmd_valid), .cmd_rd(cmd_rd), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_stb(rsp_stb), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  ssb_dev #(.BOOT_CYC(BOOT)) ssb_dev_i (.core_clk(core_clk), .arst_n(arst_n), .bus(bus),
    .tx_data(tx_data), .rd_ack_en(rd_ack_en), .hold_req(hold_req), .meas_busy(meas_busy),
    .rx_data(rx_data), .rx_stb(rx_stb), .hdr_stb(hdr_stb), .hdr_rd(hdr_rd), .tx_stb(tx_stb),
    .ready(ready), .busy(busy), .sleep(sleep));
  ssb_asserts #(.BOOT_CYC(BOOT)) ssb_asserts_i (.core_clk(core_clk), .arst_n(arst_n),
    .dev_scl_o(bus.dev_scl_o), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe), .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
    .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe), .scl(bus.scl), .sda(bus.sda));
  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  // strobes last one cycle; sampled mid-cycle, away from the edge that moves them
  always @(negedge core_clk) begin
    if (hdr_stb === 1'b1) hdr_n++;
    if (tx_stb === 1'b1) tx_n++;
    if (rx_stb === 1'b1) rx_last = rx_data;
    if (bus.dev_scl_oe === 1'b1) held_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one command: request held until taken, then wait for the response strobe
  task automatic do_cmd(input logic rd, input logic [7:0] data);
    int n;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_rd = rd;
    cmd_data = data;
    n = 0;
    // ready seen just after an edge is what the next edge samples
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_stb !== 1'b1 && n < 8000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("rsp strobe", 8'h01, {7'h0, rsp_stb});
    chk("cmd ready", 8'h01, {7'h0, cmd_ready});
    chk("idle busy", 8'h00, {7'h0, busy});
    chk("end sleep", 8'h01, {7'h0, sleep});
  endtask : do_cmd
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (BOOT + 4) @(posedge core_clk);
    #1;
    chk("ready", 8'h01, {7'h0, ready});
    chk("idle sleep", 8'h01, {7'h0, sleep});
    do_cmd(1'b0, 8'ha5);
    chk("hdr count", 8'h01, hdr_n[7:0]);
    chk("hdr dir wr", 8'h00, {7'h0, hdr_rd});
    chk("rx byte", 8'ha5, rx_last);
    chk("wr nack", 8'h00, {7'h0, rsp_nack});
    tx_data = 8'h3c;
    do_cmd(1'b1, 8'h00);
    chk("rd data", 8'h3c, rsp_data);
    chk("hdr dir rd", 8'h01, {7'h0, hdr_rd});
    chk("tx count", 8'h01, tx_n[7:0]);
    rd_ack_en = 1'b0;
    do_cmd(1'b1, 8'h00);
    chk("poll nack", 8'h01, {7'h0, rsp_nack});
    chk("poll hdr", 8'h02, hdr_n[7:0]);
    rd_ack_en = 1'b1;
    meas_busy = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("meas sleep", 8'h00, {7'h0, sleep});
    meas_busy = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("back to sleep", 8'h01, {7'h0, sleep});
    hold_req = 1'b1;
    // the clock is held well past a bit time to prove the state survives a stopped clock
    fork
      do_cmd(1'b0, 8'h5a);
      begin
        repeat (400) @(posedge core_clk);
        #1;
        chk("held busy", 8'h01, {7'h0, busy});
        chk("held scl", 8'h00, {7'h0, bus.scl});
        chk("held sleep", 8'h00, {7'h0, sleep});
        hold_req = 1'b0;
      end
    join
    chk("held seen", 8'h01, {7'h0, held_seen});
    chk("held rx", 8'h5a, rx_last);
    chk("held nack", 8'h00, {7'h0, rsp_nack});
    final_report();
  end
  // limit covers boot plus four commands and the hold with wide margin
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    final_report();
  end
endmodule : sensor_serial_bus_front_end_bench
`default_nettype wire
